// ===== rtl/psfp_synth.sv
// Purpose: Programmable N x 8 kHz synthesizer with frame pulse generator behind an APB slave
// Assumes: Single pclk domain; the synthesized clock comes from a phase accumulator on pclk
// Notes: Output clock edges are quantised to pclk; jitter is one pclk period
`timescale 1ns/10ps
module psfp_synth
   import psfp_pkg::*;
#(
   parameter longint PCLK_HZ = 100000000,
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic synth_clk_out,
   output logic synth_frame_out
);
   // Accumulator modulus: one output period spans PCLK_HZ/1000 units
   localparam longint MOD = PCLK_HZ / 1000;
   localparam longint FINE_K = (PSFP_STEP_KHZ * PSFP_FINE_STEP_FS * MOD * (64'sd1 << PSFP_FINE_SHIFT))
                               / 64'sd1000000000000;

   // Frame periods in pclk cycles
   function automatic logic [31:0] ns_to_cyc(input longint ns);
      ns_to_cyc = 32'((ns * MOD) / 64'sd1000000);
   endfunction : ns_to_cyc

   localparam logic [31:0] PER_166HZ = ns_to_cyc(PSFP_PER_166HZ_NS);
   localparam logic [31:0] PER_400HZ = ns_to_cyc(PSFP_PER_400HZ_NS);
   localparam logic [31:0] PER_1KHZ = ns_to_cyc(PSFP_PER_1KHZ_NS);
   localparam logic [31:0] PER_2KHZ = ns_to_cyc(PSFP_PER_2KHZ_NS);
   localparam logic [31:0] PER_4KHZ = ns_to_cyc(PSFP_PER_4KHZ_NS);
   localparam logic [31:0] PER_8KHZ = ns_to_cyc(PSFP_PER_8KHZ_NS);
   localparam logic [31:0] PER_64KHZ = ns_to_cyc(PSFP_PER_64KHZ_NS);
   localparam logic [31:0] PER_1HZ = ns_to_cyc(PSFP_PER_1HZ_NS);
   localparam logic [31:0] HIGH_1HZ = ns_to_cyc(PSFP_HIGH_1HZ_NS);

   // Elaboration check; the decode needs paddr[9:2] plus at least one upper address bit
   if (ADDR_W < 11 || PCLK_HZ < 64'sd8000000 || PER_64KHZ < 32'd4) begin : g_param_check
      $error("psfp_synth: unsupported parameters");
   end

   // Masked write keeps reserved bits at their reset value
   function automatic logic [7:0] wr_mask(input logic [7:0] d, input logic [7:0] m, input logic [7:0] r);
      wr_mask = (d & m) | (r & ~m);
   endfunction : wr_mask

   // Frame period for a rate code; undefined codes fall back to 8 kHz
   function automatic logic [31:0] rate_period(input logic [3:0] code);
      case (code)
         PSFP_RATE_166HZ: rate_period = PER_166HZ;
         PSFP_RATE_400HZ: rate_period = PER_400HZ;
         PSFP_RATE_1KHZ: rate_period = PER_1KHZ;
         PSFP_RATE_2KHZ: rate_period = PER_2KHZ;
         PSFP_RATE_4KHZ: rate_period = PER_4KHZ;
         PSFP_RATE_8KHZ: rate_period = PER_8KHZ;
         PSFP_RATE_64KHZ: rate_period = PER_64KHZ;
         PSFP_RATE_1HZ: rate_period = PER_1HZ;
         default: rate_period = PER_8KHZ;
      endcase
   endfunction : rate_period

   // Pulse width in cycles for width codes 000 to 100; other codes use one cycle
   function automatic logic [31:0] width_cycles(input logic [2:0] code);
      case (code)
         PSFP_WID_4M: width_cycles = PSFP_WID_4M_CYC;
         PSFP_WID_8M: width_cycles = PSFP_WID_8M_CYC;
         PSFP_WID_16M: width_cycles = PSFP_WID_16M_CYC;
         PSFP_WID_32M: width_cycles = PSFP_WID_32M_CYC;
         PSFP_WID_65M: width_cycles = PSFP_WID_65M_CYC;
         default: width_cycles = 32'h0000_0001;
      endcase
   endfunction : width_cycles

   logic [7:0] freq_low_reg;
   logic [7:0] freq_high_reg;
   logic [7:0] coarse_reg;
   logic [7:0] fine_reg;
   logic [7:0] rate_reg;
   logic [7:0] shape_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [31:0] acc_reg;
   logic synth_clk_reg;
   logic synth_clk_d_reg;
   logic [31:0] per_cnt_reg;
   logic [31:0] wid_cnt_reg;
   logic frame_reg;
   logic frame_out_reg;
   psfp_state_t state_reg;
   psfp_state_t state_next;

   // APB decode
   wire [7:0] word_idx = paddr[9:2];
   wire setup = psel & ~penable;
   wire acc_wr = psel & penable & pwrite;
   wire hit_flow = word_idx == PSFP_IDX_FREQ_LOW;
   wire hit_fhigh = word_idx == PSFP_IDX_FREQ_HIGH;
   wire hit_coarse = word_idx == PSFP_IDX_COARSE;
   wire hit_fine = word_idx == PSFP_IDX_FINE;
   wire hit_rate = word_idx == PSFP_IDX_RATE;
   wire hit_shape = word_idx == PSFP_IDX_SHAPE;
   wire hit_status = word_idx == PSFP_IDX_STATUS;
   wire mapped = (paddr[ADDR_W-1:10] == '0) & (hit_flow | hit_fhigh | hit_coarse | hit_fine |
                 hit_rate | hit_shape | hit_status);

   // Shape fields
   wire frame_style_sel = shape_reg[PSFP_SHAPE_STYLE_BIT];
   wire frame_edge_sel = shape_reg[PSFP_SHAPE_EDGE_BIT];
   wire [2:0] frame_width_code = shape_reg[PSFP_SHAPE_WIDTH_LSB +: 3];
   wire frame_invert = shape_reg[PSFP_SHAPE_INVERT_BIT];
   wire [3:0] frame_rate_code = rate_reg[3:0];
   wire is_1hz = frame_rate_code == PSFP_RATE_1HZ;

   // Read mux; status shows live output and frame state
   wire [7:0] status_val = {5'h00, state_reg == PSFP_PULSE, synth_frame_out, synth_clk_out};
   wire [7:0] rd_byte = hit_flow ? freq_low_reg :
                        hit_fhigh ? freq_high_reg :
                        hit_coarse ? coarse_reg :
                        hit_fine ? fine_reg :
                        hit_rate ? rate_reg :
                        hit_shape ? shape_reg :
                        hit_status ? status_val : 8'h00;

   // Zero wait states; read data is latched in the setup cycle
   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         pslverr_reg <= ~mapped;
      end
   end

   // Register writes; reserved bits hold their reset value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_low_reg <= PSFP_RST_FREQ_LOW;
         freq_high_reg <= PSFP_RST_FREQ_HIGH;
         coarse_reg <= PSFP_RST_COARSE;
         fine_reg <= PSFP_RST_FINE;
         rate_reg <= PSFP_RST_RATE;
         shape_reg <= PSFP_RST_SHAPE;
      end else if (acc_wr && mapped) begin
         if (hit_flow) freq_low_reg <= wr_mask(pwdata[7:0], PSFP_WM_FREQ_LOW, PSFP_RST_FREQ_LOW);
         if (hit_fhigh) freq_high_reg <= wr_mask(pwdata[7:0], PSFP_WM_FREQ_HIGH, PSFP_RST_FREQ_HIGH);
         if (hit_coarse) coarse_reg <= wr_mask(pwdata[7:0], PSFP_WM_COARSE, PSFP_RST_COARSE);
         if (hit_fine) fine_reg <= wr_mask(pwdata[7:0], PSFP_WM_FINE, PSFP_RST_FINE);
         if (hit_rate) rate_reg <= wr_mask(pwdata[7:0], PSFP_WM_RATE, PSFP_RST_RATE);
         if (hit_shape) shape_reg <= wr_mask(pwdata[7:0], PSFP_WM_SHAPE, PSFP_RST_SHAPE);
      end
   end

   // Multiplier N and accumulator increment, 8 units of 1 kHz per step
   wire [13:0] freq_mult = {freq_high_reg[5:0], freq_low_reg};
   wire [31:0] acc_inc = {15'h0000, freq_mult, 3'h0};
   wire [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, acc_inc};
   wire [32:0] acc_wrap = acc_sum - 33'(MOD);
   wire [31:0] acc_next = (acc_sum >= 33'(MOD)) ? acc_wrap[31:0] : acc_sum[31:0];

   // Phase offsets: coarse in quarter periods, fine scaled by N so one step is constant in time
   wire signed [47:0] coarse_off = 48'(coarse_reg[1:0]) * 48'(MOD / 4);
   wire signed [47:0] fine_prod = 48'($signed(fine_reg)) * $signed({34'h0, freq_mult}) * 48'(FINE_K);
   wire signed [47:0] fine_off = fine_prod >>> PSFP_FINE_SHIFT;
   wire signed [47:0] phase_raw = $signed({16'h0000, acc_reg}) + coarse_off + fine_off;
   wire signed [47:0] phase_rem = phase_raw % 48'(MOD);
   wire signed [47:0] phase_mod = (phase_rem < 0) ? phase_rem + 48'(MOD) : phase_rem;
   wire clk_level = phase_mod >= 48'(MOD / 2);

   // Accumulator and synthesized clock; output comes straight from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= 32'h0000_0000;
         synth_clk_reg <= 1'b0;
         synth_clk_d_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         synth_clk_reg <= clk_level;
         synth_clk_d_reg <= synth_clk_reg;
      end
   end

   assign synth_clk_out = synth_clk_reg;

   // Trigger edge of the synthesized clock; 1 Hz ignores the falling selection
   wire clk_rise = synth_clk_reg & ~synth_clk_d_reg;
   wire clk_fall = ~synth_clk_reg & synth_clk_d_reg;
   wire use_fall = frame_edge_sel & ~is_1hz;
   wire edge_hit = use_fall ? clk_fall : clk_rise;

   // Frame period counter
   wire [31:0] period = rate_period(frame_rate_code);
   wire per_wrap = per_cnt_reg >= period - 32'h0000_0001;

   // Pulse length: half period or 4 ms in clock style, width code in pulse style
   wire [31:0] half_len = is_1hz ? HIGH_1HZ : (period >> 1);
   wire [31:0] pulse_len = frame_style_sel ? width_cycles(frame_width_code) : half_len;
   wire one_clk_mode = frame_style_sel & (frame_width_code == PSFP_WID_PCLK);
   wire pulse_done = one_clk_mode ? edge_hit : (wid_cnt_reg <= 32'h0000_0001);

   // Frame state: armed on a period tick outside the pulse or in its last cycle, pulse starts on the selected clock edge
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PSFP_IDLE: begin
            if (per_wrap) state_next = PSFP_ARMED;
         end
         PSFP_ARMED: begin
            if (edge_hit) state_next = PSFP_PULSE;
         end
         PSFP_PULSE: begin
            if (pulse_done) state_next = per_wrap ? PSFP_ARMED : PSFP_IDLE;
         end
         default: state_next = PSFP_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= PSFP_IDLE;
         per_cnt_reg <= 32'h0000_0000;
         wid_cnt_reg <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         per_cnt_reg <= per_wrap ? 32'h0000_0000 : per_cnt_reg + 32'h0000_0001;
         if (state_reg == PSFP_ARMED && edge_hit) begin
            wid_cnt_reg <= pulse_len;
         end else if (state_reg == PSFP_PULSE && wid_cnt_reg != 32'h0000_0000) begin
            wid_cnt_reg <= wid_cnt_reg - 32'h0000_0001;
         end
      end
   end

   // Polarity applied at the output flop so the pin never glitches
   assign frame_reg = state_reg == PSFP_PULSE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_out_reg <= 1'b0;
      end else begin
         frame_out_reg <= frame_reg ^ frame_invert;
      end
   end

   assign synth_frame_out = frame_out_reg;
endmodule : psfp_synth

// ===== rtl/psfp_pkg.sv
// Purpose: Shared constants for the programmable synthesizer and frame pulse block
// Assumes: 100 MHz pclk, byte-wide registers on a 32-bit APB bus
// Notes: Register indices are word indices; the byte address is four times the index
package psfp_pkg;
   // Register indices
   localparam logic [7:0] PSFP_IDX_FREQ_LOW = 8'h38;
   localparam logic [7:0] PSFP_IDX_FREQ_HIGH = 8'h39;
   localparam logic [7:0] PSFP_IDX_COARSE = 8'h3A;
   localparam logic [7:0] PSFP_IDX_FINE = 8'h3D;
   localparam logic [7:0] PSFP_IDX_RATE = 8'h3E;
   localparam logic [7:0] PSFP_IDX_SHAPE = 8'h3F;
   localparam logic [7:0] PSFP_IDX_STATUS = 8'h30;

   // Reset values
   localparam logic [7:0] PSFP_RST_FREQ_LOW = 8'h00;
   localparam logic [7:0] PSFP_RST_FREQ_HIGH = 8'h01;
   localparam logic [7:0] PSFP_RST_COARSE = 8'h00;
   localparam logic [7:0] PSFP_RST_FINE = 8'h00;
   localparam logic [7:0] PSFP_RST_RATE = 8'h05;
   localparam logic [7:0] PSFP_RST_SHAPE = 8'h83;

   // Writable bit masks; other bits keep their reset value
   localparam logic [7:0] PSFP_WM_FREQ_LOW = 8'hFF;
   localparam logic [7:0] PSFP_WM_FREQ_HIGH = 8'h3F;
   localparam logic [7:0] PSFP_WM_COARSE = 8'h03;
   localparam logic [7:0] PSFP_WM_FINE = 8'hFF;
   localparam logic [7:0] PSFP_WM_RATE = 8'h0F;
   localparam logic [7:0] PSFP_WM_SHAPE = 8'hF3;

   // Shape register field positions
   localparam int PSFP_SHAPE_STYLE_BIT = 0;
   localparam int PSFP_SHAPE_EDGE_BIT = 1;
   localparam int PSFP_SHAPE_WIDTH_LSB = 4;
   localparam int PSFP_SHAPE_INVERT_BIT = 7;

   // Frame rate codes
   localparam logic [3:0] PSFP_RATE_166HZ = 4'h0;
   localparam logic [3:0] PSFP_RATE_400HZ = 4'h1;
   localparam logic [3:0] PSFP_RATE_1KHZ = 4'h2;
   localparam logic [3:0] PSFP_RATE_2KHZ = 4'h3;
   localparam logic [3:0] PSFP_RATE_4KHZ = 4'h4;
   localparam logic [3:0] PSFP_RATE_8KHZ = 4'h5;
   localparam logic [3:0] PSFP_RATE_64KHZ = 4'h7;
   localparam logic [3:0] PSFP_RATE_1HZ = 4'h8;

   // Frame periods in ns
   localparam longint PSFP_PER_166HZ_NS = 6000000;
   localparam longint PSFP_PER_400HZ_NS = 2500000;
   localparam longint PSFP_PER_1KHZ_NS = 1000000;
   localparam longint PSFP_PER_2KHZ_NS = 500000;
   localparam longint PSFP_PER_4KHZ_NS = 250000;
   localparam longint PSFP_PER_8KHZ_NS = 125000;
   localparam longint PSFP_PER_64KHZ_NS = 15625;
   localparam longint PSFP_PER_1HZ_NS = 1000000000;
   localparam longint PSFP_HIGH_1HZ_NS = 4000000;

   // Width codes and pulse widths in ps
   localparam logic [2:0] PSFP_WID_4M = 3'h0;
   localparam logic [2:0] PSFP_WID_8M = 3'h1;
   localparam logic [2:0] PSFP_WID_16M = 3'h2;
   localparam logic [2:0] PSFP_WID_32M = 3'h3;
   localparam logic [2:0] PSFP_WID_65M = 3'h4;
   localparam logic [2:0] PSFP_WID_PCLK = 3'h7;
   localparam longint PSFP_WID_4M_PS = 244141;
   localparam longint PSFP_WID_8M_PS = 122071;
   localparam longint PSFP_WID_16M_PS = 61036;
   localparam longint PSFP_WID_32M_PS = 30518;
   localparam longint PSFP_WID_65M_PS = 15259;
   localparam longint PSFP_CLK_PERIOD_PS = 10000;
   localparam logic [31:0] PSFP_WID_4M_CYC = 32'((PSFP_WID_4M_PS + PSFP_CLK_PERIOD_PS - 1) / PSFP_CLK_PERIOD_PS);
   localparam logic [31:0] PSFP_WID_8M_CYC = 32'((PSFP_WID_8M_PS + PSFP_CLK_PERIOD_PS - 1) / PSFP_CLK_PERIOD_PS);
   localparam logic [31:0] PSFP_WID_16M_CYC = 32'((PSFP_WID_16M_PS + PSFP_CLK_PERIOD_PS - 1) / PSFP_CLK_PERIOD_PS);
   localparam logic [31:0] PSFP_WID_32M_CYC = 32'((PSFP_WID_32M_PS + PSFP_CLK_PERIOD_PS - 1) / PSFP_CLK_PERIOD_PS);
   localparam logic [31:0] PSFP_WID_65M_CYC = 32'((PSFP_WID_65M_PS + PSFP_CLK_PERIOD_PS - 1) / PSFP_CLK_PERIOD_PS);

   // Synthesis step and fine phase step
   localparam longint PSFP_STEP_KHZ = 8;
   localparam longint PSFP_FINE_STEP_FS = 119200;
   localparam int PSFP_FINE_SHIFT = 20;

   // Frame generator states
   typedef enum logic [2:0] {
      PSFP_IDLE = 3'b001,
      PSFP_ARMED = 3'b010,
      PSFP_PULSE = 3'b100
   } psfp_state_t;
endpackage : psfp_pkg

// ===== testbench/psfp_chk.sv
// Purpose: Port-level assertions for the synthesizer and frame pulse block
// Assumes: One pclk domain; the shape register is shadowed from APB writes
// Notes: Width bound allows one pclk of edge quantisation
`timescale 1ns/10ps
module psfp_chk
   import psfp_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic synth_clk_out,
   input wire logic synth_frame_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] shape_reg;
   logic [15:0] run_reg;
   logic [15:0] hold_reg;
   logic clk_q;
   // Address decode and shadow controls
   wire logic [7:0] idx = paddr[9:2];
   wire logic setup = psel && !penable;
   wire logic mapped = paddr[ADDR_W-1:10] == '0 && (idx inside {PSFP_IDX_FREQ_LOW, PSFP_IDX_FREQ_HIGH,
      PSFP_IDX_COARSE, PSFP_IDX_FINE, PSFP_IDX_RATE, PSFP_IDX_SHAPE, PSFP_IDX_STATUS});
   wire logic wr_shape = psel && penable && pwrite && mapped && idx == PSFP_IDX_SHAPE;
   wire logic active = synth_frame_out != shape_reg[7];
   wire logic [2:0] code = shape_reg[6:4];
   wire logic [31:0] lim = 32'((244141 >> code) / 10000 + 1);
   // Run counters; a shape write restarts the pulse count, since config acts at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shape_reg <= PSFP_RST_SHAPE;
         run_reg <= '0;
         hold_reg <= '0;
         clk_q <= 1'b0;
      end else begin
         clk_q <= synth_clk_out;
         hold_reg <= (synth_clk_out != clk_q) ? 16'h0000 : hold_reg + 16'h0001;
         run_reg <= (active && !wr_shape) ? run_reg + 16'h0001 : 16'h0000;
         if (wr_shape) shape_reg <= (pwdata[7:0] & PSFP_WM_SHAPE) | (PSFP_RST_SHAPE & ~PSFP_WM_SHAPE);
      end
   end
   ready_high_a: assert property (pready) else $error("pready low");
   upper_zero_a: assert property (psel && penable |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read lanes not zero");
   read_hold_a: assert property (psel && penable |=> $stable(prdata) && $stable(pslverr))
      else $error("read answer moved before next setup");
   err_map_a: assert property (setup |=> pslverr == !$past(mapped))
      else $error("error flag does not match decode");
   err_zero_a: assert property (psel && penable && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused read returned data");
   shape_read_a: assert property (setup && !pwrite && mapped && idx == PSFP_IDX_SHAPE |=>
      prdata[7:0] == $past(shape_reg)) else $error("shape readback wrong");
   clk_alive_a: assert property (hold_reg < 16'd6300) else $error("synth clock stalled");
   width_limit_a: assert property (shape_reg[0] && code <= 3'h4 |-> run_reg <= lim + 1)
      else $error("frame pulse too long");
   cover property (setup ##1 pslverr);
   cover property (active && code == 3'h7);
   cover property (active && !shape_reg[0] && run_reg > 16'd1000);
endmodule : psfp_chk
bind psfp_synth psfp_chk #(.ADDR_W(ADDR_W)) i_psfp_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .synth_clk_out(synth_clk_out), .synth_frame_out(synth_frame_out));

// ===== testbench/psfp_sink.sv
// Purpose: Consumer of the synthesized clock and frame pulse; measures them in pclk cycles
// Assumes: Outputs sampled on pclk, so figures carry one cycle of quantisation
// Notes: act_lvl gives the active level of the frame signal
`timescale 1ns/10ps
module psfp_sink (
   input wire logic pclk,
   input wire logic synth_clk_out,
   input wire logic synth_frame_out,
   input wire logic act_lvl,
   output int clk_per,
   output int frm_per,
   output int frm_wid,
   output int s_rise,
   output int s_fall,
   output int frm_cnt,
   output int rise_at
);
   int cyc = 0;
   int fall_t = 0;
   int fstart = 0;
   logic ck_q = 1'b0;
   logic fr_q = 1'b0;
   wire logic act = synth_frame_out == act_lvl;
   // Edge timing of clock and frame; sampled on the falling edge, where the design's flops have settled
   always @(negedge pclk) begin
      cyc <= cyc + 1;
      ck_q <= synth_clk_out;
      fr_q <= act;
      if (synth_clk_out && !ck_q) begin
         clk_per <= cyc - rise_at;
         rise_at <= cyc;
      end
      if (!synth_clk_out && ck_q) fall_t <= cyc;
      if (act && !fr_q) begin
         frm_per <= cyc - fstart;
         fstart <= cyc;
         s_rise <= cyc - rise_at;
         s_fall <= cyc - fall_t;
         frm_cnt <= frm_cnt + 1;
      end
      if (!act && fr_q) frm_wid <= cyc - fstart;
   end
endmodule : psfp_sink

// ===== testbench/psfp_synth_tb_top.sv
// Purpose: Self-checking bench for the synthesizer and frame pulse block
// Assumes: 100 MHz pclk and a zero-wait APB slave
// Notes: 1 Hz and rates below 8 kHz are left out to keep the run short
`timescale 1ns/10ps
module psfp_synth_tb_top
   import psfp_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lvl = 1, er;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, synth_clk_out, synth_frame_out;
   int failures = 0, check_count = 0, clk_per, frm_per, frm_wid, s_rise, s_fall, frm_cnt, rise_at, base, r;
   logic [7:0] ix [6] = '{PSFP_IDX_FREQ_LOW, PSFP_IDX_FREQ_HIGH, PSFP_IDX_COARSE, PSFP_IDX_FINE,
      PSFP_IDX_RATE, PSFP_IDX_SHAPE};
   logic [7:0] rst [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h05, 8'h83};
   logic [7:0] wm [6] = '{8'hFF, 8'h3F, 8'h03, 8'hFF, 8'h0F, 8'hF3};
   psfp_synth i_psfp_synth (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .synth_clk_out(synth_clk_out), .synth_frame_out(synth_frame_out));
   psfp_sink i_psfp_sink (.pclk(pclk), .synth_clk_out(synth_clk_out), .synth_frame_out(synth_frame_out),
      .act_lvl(lvl), .clk_per(clk_per), .frm_per(frm_per), .frm_wid(frm_wid), .s_rise(s_rise),
      .s_fall(s_fall), .frm_cnt(frm_cnt), .rise_at(rise_at));
   initial begin
      forever #5 pclk = ~pclk;
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic near(input int got, input int exp, input int tol);
      chk((got >= exp - tol && got <= exp + tol) ? exp : got, exp);
   endtask : near
   // One APB transfer; the answer is taken at the edge where pready is seen high
   task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] i, input logic [31:0] exp, input logic eerr);
      apb(1'b0, i, 8'h00);
      chk(rd, exp);
      chk({31'h0, er}, {31'h0, eerr});
   endtask : rdc
   // Low byte first so N never passes through zero for long
   task automatic setn(input logic [7:0] lo, input logic [7:0] hi);
      apb(1'b1, PSFP_IDX_FREQ_LOW, lo);
      apb(1'b1, PSFP_IDX_FREQ_HIGH, hi);
   endtask : setn
   // Wait for k frame starts, then for the pulse to end
   task automatic frames(input int k);
      int c0;
      int n;
      c0 = frm_cnt;
      n = 0;
      // Polled on the falling edge so the frame output is never read as it changes
      while ((frm_cnt < c0 + k || synth_frame_out === lvl) && n < 70000) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 70000) begin
         failures++;
         finish_test();
      end
      @(posedge pclk);
   endtask : frames
   // Phase distance of the latest clock rise from the base, folded to one side
   function automatic int fold();
      int m;
      m = (rise_at - base) % 100;
      return (m > 50) ? 100 - m : m;
   endfunction : fold
   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      finish_test();
   end
   initial begin
      void'($urandom(27));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) rdc(ix[i], {24'h0, rst[i]}, 1'b0);
      rdc(8'($urandom_range(47)), 32'h0000_0000, 1'b1);
      for (int i = 0; i < 6; i++) begin
         r = $urandom | ((i == 1 || i == 5) ? 1 : 0);
         apb(1'b1, ix[i], r[7:0]);
         rdc(ix[i], {24'h0, (r[7:0] & wm[i]) | (rst[i] & ~wm[i])}, 1'b0);
      end
      apb(1'b1, PSFP_IDX_COARSE, 8'h00);
      apb(1'b1, PSFP_IDX_FINE, 8'h00);
      setn(8'h71, 8'h02);
      repeat (100) @(posedge pclk);
      near(clk_per, 20, 0);
      setn(8'h7D, 8'h00);
      repeat (300) @(posedge pclk);
      near(clk_per, 100, 0);
      base = rise_at;
      for (int q = 1; q < 4; q++) begin
         apb(1'b1, PSFP_IDX_COARSE, 8'(q));
         repeat (300) @(posedge pclk);
         near(fold(), (q == 2) ? 50 : 25, 1);
      end
      apb(1'b1, PSFP_IDX_COARSE, 8'h00);
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, PSFP_IDX_FINE, f ? 8'h80 : 8'h7F);
         repeat (300) @(posedge pclk);
         near(fold(), 2, 1);
      end
      apb(1'b1, PSFP_IDX_FINE, 8'h00);
      apb(1'b1, PSFP_IDX_RATE, 8'h07);
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, PSFP_IDX_SHAPE, 8'h71 | 8'(e << 1));
         frames(3);
         near(frm_wid, 100, 1);
         near(e ? s_fall : s_rise, 2, 2);
      end
      setn(8'h00, 8'h01);
      for (int c = 0; c < 5; c++) begin
         lvl <= ~c[0];
         apb(1'b1, PSFP_IDX_SHAPE, {c[0], 3'(c), 4'h1});
         frames(3);
         near(frm_wid, (244141 >> c) / 10000 + 1, 1);
         near(frm_per, 1563, 2);
      end
      lvl <= 1'b0;
      apb(1'b1, PSFP_IDX_RATE, 8'h05);
      apb(1'b1, PSFP_IDX_SHAPE, 8'h80);
      frames(3);
      near(frm_per, 12500, 2);
      near(frm_wid, 6250, 2);
      // Reset in mid-run: registers return to reset values and the frame output idles inverted
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) rdc(ix[i], {24'h0, rst[i]}, 1'b0);
      apb(1'b0, PSFP_IDX_STATUS, 8'h00);
      chk({rd[31:1], er}, 32'h0000_0002);
      finish_test();
   end
endmodule : psfp_synth_tb_top
